// >>> bsd_pkg.sv
// Shared constants and types for the bit-operation and add-and-skip executor
package bsd_pkg;

  // ---------------------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------------------
  localparam logic [7:0] OP_ADC_A_MEM    = 8'h3E;
  localparam logic [7:0] OP_ADS_A_MEM    = 8'h3F;
  localparam logic [3:0] OP_ADS_A_IMM_HI = 4'hA;
  localparam logic [7:0] OP_ADS_EA_IMM   = 8'hC9;
  localparam logic [7:0] OP_PAIR_PFX     = 8'hDC;
  localparam logic [3:0] SUB_ADC_PAIR    = 4'hA;
  localparam logic [3:0] SUB_ADS_PAIR    = 4'h9;
  localparam int         SUB_DST_EA_POS  = 3;
  localparam logic [7:0] OP_BIT_SET      = 8'hFF;
  localparam logic [7:0] OP_BIT_CLR      = 8'hFE;
  localparam logic [7:0] OP_CY_AND       = 8'hF5;
  localparam logic [7:0] OP_CY_OR        = 8'hF6;
  localparam logic [7:0] OP_CY_XOR       = 8'hF7;
  localparam logic [7:0] OP_LD_TO_BIT    = 8'hFC;
  localparam logic [7:0] OP_LD_TO_CY     = 8'hF4;

  // ---------------------------------------------------------------------------
  // Bit addressing fields
  // ---------------------------------------------------------------------------
  localparam logic [1:0] DA_FORM_HI   = 2'b11;
  localparam logic [2:0] DA_FORM_MID  = 3'b000;
  localparam int         BSEL_LSB     = 4;
  localparam int         FIX_FLAG_POS = 7;
  localparam int         FIX_AREA_POS = 6;
  localparam logic [3:0] FIX_BANK     = 4'hF;
  localparam logic [3:0] FIX_AREA_LO  = 4'hB;
  localparam logic [3:0] FIX_AREA_HI  = 4'hF;
  localparam logic [3:0] LIDX_TAG     = 4'h4;
  localparam logic [1:0] LIDX_TOP     = 2'b11;

  // ---------------------------------------------------------------------------
  // Sizes and timing
  // ---------------------------------------------------------------------------
  localparam int         CNT_W       = 8;
  localparam logic [1:0] BYTES_SHORT = 2'd1;
  localparam logic [1:0] BYTES_LONG  = 2'd2;
  localparam int         MC_DIV_DEF  = 4;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_LAT, ST_EXEC, ST_HOLD} bsd_state_e;

  typedef enum logic [3:0] {
    K_NONE, K_ADC4, K_ADS4M, K_ADS4I, K_ADS8I, K_ADC8, K_ADS8,
    K_BSET, K_BCLR, K_BAND, K_BOR, K_CARRY_XOR_BIT, K_BTOM, K_BTOC
  } bsd_kind_e;

  typedef struct packed {
    logic [7:0] first;
    logic [7:0] second;
    logic [1:0] len;
  } bsd_op_s;

  typedef struct packed {
    logic [3:0] acc;
    logic [3:0] ext;
    logic [3:0] h;
    logic [3:0] l;
    logic       carry;
    logic [3:0] bank;
  } bsd_regs_s;

  typedef struct packed {
    logic       acc_we;
    logic [3:0] acc;
    logic       ext_we;
    logic [3:0] ext;
    logic       rr_we;
    logic [1:0] rr_sel;
    logic [7:0] rr;
    logic       cy_we;
    logic       cy;
    logic       mem_we;
    logic [3:0] mem;
  } bsd_wb_s;

  typedef struct packed {
    bsd_state_e       state;
    logic [CNT_W-1:0] cnt;
    bsd_kind_e        kind;
    bsd_op_s          op;
    bsd_regs_s        regs;
    logic [3:0]       memd;
    logic [1:0]       bitn;
    logic [1:0]       ncyc;
    logic             skipping;
    logic             no_skip;
    logic             skip_req;
    logic             skip_pend;
    logic             prev_adc;
    logic             adc_cy;
    logic             mem_rd;
    logic [11:0]      mem_addr;
    logic [1:0]       rr_sel;
    bsd_wb_s          wbp;
    bsd_wb_s          wb;
    logic             done;
    logic             ready;
  } bsd_st_s;

endpackage

// >>> bsd_adder.sv
// Shared 4-bit / 8-bit adder with carry-in and carry-out
module bsd_adder
  import bsd_pkg::*;
(
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  input  wire logic       wide,
  output logic      [7:0] sum,
  output logic            cout
);

  logic [8:0] full;
  logic [4:0] half;

  assign full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  assign half = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
  assign sum  = wide ? full[7:0] : {4'h0, half[3:0]};
  assign cout = wide ? full[8] : half[4];

endmodule

// >>> bsd_decoder.sv
// Executor for bit operations, add-with-carry and add-and-skip instructions
module bsd_decoder
  import bsd_pkg::*;
#(
  parameter int MC_DIV = MC_DIV_DEF
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        issue,
  input  wire bsd_op_s     issue_op,
  input  wire bsd_regs_s   issue_regs,
  output logic             ready,
  output logic             mem_rd,
  output logic      [11:0] mem_addr,
  input  wire logic [3:0]  mem_rdata,
  output logic      [1:0]  rr_sel,
  input  wire logic [7:0]  rr_rdata,
  output bsd_wb_s          wb,
  output logic             done,
  output logic             skip_pending
);

  // ---------------------------------------------------------------------------
  // Decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic is_da_form(input logic [7:0] f);
    return (f[7:6] == DA_FORM_HI) && (f[3:1] == DA_FORM_MID);
  endfunction

  function automatic bsd_kind_e kind_of(input logic [7:0] f, input logic [7:0] s);
    bsd_kind_e k;
    k = K_NONE;
    if (f == OP_ADC_A_MEM) k = K_ADC4;
    else if (f == OP_ADS_A_MEM) k = K_ADS4M;
    else if (f[7:4] == OP_ADS_A_IMM_HI) k = K_ADS4I;
    else if (f == OP_ADS_EA_IMM) k = K_ADS8I;
    else if (f == OP_PAIR_PFX && s[7:4] == SUB_ADC_PAIR && !s[0]) k = K_ADC8;
    else if (f == OP_PAIR_PFX && s[7:4] == SUB_ADS_PAIR && !s[0]) k = K_ADS8;
    else if (f == OP_BIT_SET) k = K_BSET;
    else if (f == OP_BIT_CLR) k = K_BCLR;
    else if (f == OP_CY_AND) k = K_BAND;
    else if (f == OP_CY_OR) k = K_BOR;
    else if (f == OP_CY_XOR) k = K_CARRY_XOR_BIT;
    else if (f == OP_LD_TO_BIT) k = K_BTOM;
    else if (f == OP_LD_TO_CY) k = K_BTOC;
    else if (is_da_form(f)) k = f[0] ? K_BSET : K_BCLR;
    return k;
  endfunction

  function automatic logic is_bit(input bsd_kind_e k);
    return k inside {K_BSET, K_BCLR, K_BAND, K_BOR, K_CARRY_XOR_BIT, K_BTOM, K_BTOC};
  endfunction

  function automatic logic is_ads(input bsd_kind_e k);
    return k inside {K_ADS4M, K_ADS4I, K_ADS8I, K_ADS8};
  endfunction

  function automatic logic [1:0] bytes_of(input bsd_kind_e k, input logic [1:0] len);
    logic [1:0] b;
    case (k)
      K_ADC4, K_ADS4M, K_ADS4I: b = BYTES_SHORT;
      K_NONE:                   b = len;
      default:                  b = BYTES_LONG;
    endcase
    return b;
  endfunction

  // Returns {nibble address, bit number}
  function automatic logic [13:0] addr_of(input bsd_op_s op, input bsd_regs_s r);
    logic [13:0] v;
    if (is_da_form(op.first)) begin
      v = {r.bank, op.second, op.first[BSEL_LSB +: 2]};
    end else if (op.second[FIX_FLAG_POS]) begin
      v = {FIX_BANK, op.second[FIX_AREA_POS] ? FIX_AREA_HI : FIX_AREA_LO,
           op.second[3:0], op.second[BSEL_LSB +: 2]};
    end else if (op.second[7:4] == LIDX_TAG) begin
      v = {FIX_BANK, LIDX_TOP, op.second[3:0], r.l[3:2], r.l[1:0]};
    end else begin
      v = {r.bank, r.h, op.second[3:0], op.second[BSEL_LSB +: 2]};
    end
    return v;
  endfunction

  function automatic logic [3:0] put_bit(input logic [3:0] nib, input logic [1:0] b,
                                         input logic v);
    logic [3:0] t;
    t    = nib;
    t[b] = v;
    return t;
  endfunction

  function automatic logic [CNT_W-1:0] end_of(input logic [1:0] ncyc);
    return CNT_W'(int'(ncyc) * MC_DIV - 1);
  endfunction

  // ---------------------------------------------------------------------------
  // Issue and adder operands
  // ---------------------------------------------------------------------------
  bsd_st_s    s_q;
  bsd_st_s    s_d;
  logic       accept;
  bsd_kind_e  acc_kind;
  logic       acc_pair_skip;
  logic       acc_skip;
  logic       dst_ea;
  logic [7:0] ea;
  logic       pair_op;
  logic [7:0] add_a;
  logic [7:0] add_b;
  logic       add_cin;
  logic       add_wide;
  logic [7:0] add_sum;
  logic       add_cout;
  logic       cur_bit;

  assign accept        = issue && s_q.ready;
  assign acc_kind      = kind_of(issue_op.first, issue_op.second);
  assign acc_pair_skip = (acc_kind == K_ADS4I) && s_q.prev_adc && s_q.adc_cy;
  assign acc_skip      = s_q.skip_pend || acc_pair_skip;

  assign dst_ea   = s_q.op.second[SUB_DST_EA_POS];
  assign ea       = {s_q.regs.ext, s_q.regs.acc};
  assign pair_op  = (s_q.kind == K_ADC8) || (s_q.kind == K_ADS8);
  // Source is only read, never routed to a write port
  assign add_a    = (s_q.kind == K_ADS8I) ? ea :
                    pair_op ? (dst_ea ? ea : rr_rdata) : {4'h0, s_q.regs.acc};
  assign add_b    = (s_q.kind == K_ADS4I) ? {4'h0, s_q.op.first[3:0]} :
                    (s_q.kind == K_ADS8I) ? s_q.op.second :
                    pair_op ? (dst_ea ? rr_rdata : ea) : {4'h0, mem_rdata};
  assign add_cin  = ((s_q.kind == K_ADC4) || (s_q.kind == K_ADC8)) && s_q.regs.carry;
  assign add_wide = !(s_q.kind inside {K_ADC4, K_ADS4M, K_ADS4I});
  assign cur_bit  = mem_rdata[s_q.bitn];

  bsd_adder u_adder (
    .a    (add_a),
    .b    (add_b),
    .cin  (add_cin),
    .wide (add_wide),
    .sum  (add_sum),
    .cout (add_cout)
  );

  // ---------------------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------------------
  always_comb begin
    s_d           = s_q;
    s_d.done      = 1'b0;
    s_d.mem_rd    = 1'b0;
    s_d.wb.acc_we = 1'b0;
    s_d.wb.ext_we = 1'b0;
    s_d.wb.rr_we  = 1'b0;
    s_d.wb.cy_we  = 1'b0;
    s_d.wb.mem_we = 1'b0;
    s_d.cnt       = s_q.cnt + CNT_W'(1);
    case (s_q.state)
      ST_IDLE: begin
        s_d.cnt = '0;
        if (accept) begin
          s_d.op       = issue_op;
          s_d.regs     = issue_regs;
          s_d.kind     = acc_kind;
          s_d.skipping = acc_skip;
          s_d.no_skip  = (acc_kind == K_ADS4I) && s_q.prev_adc && !s_q.adc_cy;
          s_d.ncyc     = bytes_of(acc_kind, issue_op.len);
          s_d.skip_req = 1'b0;
          s_d.wbp      = '0;
          s_d.ready    = 1'b0;
          // Skipped or foreign opcodes only burn their fetch time
          s_d.state    = (acc_skip || acc_kind == K_NONE) ? ST_HOLD : ST_ADDR;
        end
      end
      ST_ADDR: begin
        s_d.mem_rd = (s_q.kind inside {K_ADC4, K_ADS4M}) || is_bit(s_q.kind);
        s_d.rr_sel = s_q.op.second[2:1];
        if (is_bit(s_q.kind)) begin
          {s_d.mem_addr, s_d.bitn} = addr_of(s_q.op, s_q.regs);
        end else begin
          s_d.mem_addr = {s_q.regs.bank, s_q.regs.h, s_q.regs.l};
          s_d.bitn     = 2'd0;
        end
        s_d.state = ST_LAT;
      end
      ST_LAT: begin
        s_d.state = ST_EXEC;
      end
      ST_EXEC: begin
        s_d.memd       = mem_rdata;
        s_d.wbp.rr_sel = s_q.rr_sel;
        case (s_q.kind)
          K_ADC4: begin
            s_d.wbp.acc_we = 1'b1;
            s_d.wbp.acc    = add_sum[3:0];
            s_d.wbp.cy_we  = 1'b1;
            s_d.wbp.cy     = add_cout;
          end
          K_ADS4M, K_ADS4I: begin
            s_d.wbp.acc_we = 1'b1;
            s_d.wbp.acc    = add_sum[3:0];
            s_d.skip_req   = add_cout && !s_q.no_skip;
          end
          K_ADS8I: begin
            s_d.wbp.acc_we = 1'b1;
            s_d.wbp.ext_we = 1'b1;
            {s_d.wbp.ext, s_d.wbp.acc} = add_sum;
            s_d.skip_req   = add_cout;
          end
          K_ADC8, K_ADS8: begin
            if (dst_ea) begin
              s_d.wbp.acc_we = 1'b1;
              s_d.wbp.ext_we = 1'b1;
              {s_d.wbp.ext, s_d.wbp.acc} = add_sum;
            end else begin
              s_d.wbp.rr_we = 1'b1;
              s_d.wbp.rr    = add_sum;
            end
            if (s_q.kind == K_ADC8) begin
              s_d.wbp.cy_we = 1'b1;
              s_d.wbp.cy    = add_cout;
            end else begin
              s_d.skip_req = add_cout;
            end
          end
          K_BSET: begin
            s_d.wbp.mem_we = 1'b1;
            s_d.wbp.mem    = put_bit(mem_rdata, s_q.bitn, 1'b1);
          end
          K_BCLR: begin
            s_d.wbp.mem_we = 1'b1;
            s_d.wbp.mem    = put_bit(mem_rdata, s_q.bitn, 1'b0);
          end
          K_BAND: begin
            s_d.wbp.cy_we = 1'b1;
            s_d.wbp.cy    = s_q.regs.carry & cur_bit;
          end
          K_BOR: begin
            s_d.wbp.cy_we = 1'b1;
            s_d.wbp.cy    = s_q.regs.carry | cur_bit;
          end
          K_CARRY_XOR_BIT: begin
            s_d.wbp.cy_we = 1'b1;
            s_d.wbp.cy    = s_q.regs.carry ^ cur_bit;
          end
          K_BTOM: begin
            s_d.wbp.mem_we = 1'b1;
            s_d.wbp.mem    = put_bit(mem_rdata, s_q.bitn, s_q.regs.carry);
          end
          K_BTOC: begin
            s_d.wbp.cy_we = 1'b1;
            s_d.wbp.cy    = cur_bit;
          end
          default: begin
          end
        endcase
        s_d.state = ST_HOLD;
      end
      ST_HOLD: begin
        if (s_q.cnt == end_of(s_q.ncyc)) begin
          s_d.done      = 1'b1;
          s_d.ready     = 1'b1;
          s_d.state     = ST_IDLE;
          s_d.wb        = s_q.skipping ? '0 : s_q.wbp;
          s_d.skip_pend = !s_q.skipping && s_q.skip_req;
          s_d.prev_adc  = !s_q.skipping && (s_q.kind == K_ADC4);
          s_d.adc_cy    = s_q.wbp.cy;
        end
      end
      default: begin
        s_d       = '0;
        s_d.ready = 1'b1;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s_q       <= '0;
      s_q.ready <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign ready        = s_q.ready;
  assign mem_rd       = s_q.mem_rd;
  assign mem_addr     = s_q.mem_addr;
  assign rr_sel       = s_q.rr_sel;
  assign wb           = s_q.wb;
  assign done         = s_q.done;
  assign skip_pending = s_q.skip_pend;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  // Done is registered one edge after the last hold count, so seen one edge later
  localparam int LAT1      = MC_DIV + 1;
  localparam int LAT2      = 2 * MC_DIV + 1;
  localparam int LAT1_REST = MC_DIV - 2;

  logic [4:0] chk_sum_c;
  logic [4:0] chk_sum_n;
  logic       fin;
  logic [3:0] one_hot;

  assign chk_sum_c = {1'b0, s_q.regs.acc} + {1'b0, s_q.memd} + {4'h0, s_q.regs.carry};
  assign chk_sum_n = {1'b0, s_q.regs.acc} + {1'b0, s_q.memd};
  assign fin       = s_q.done && !s_q.skipping;
  assign one_hot   = 4'h1 << s_q.bitn;

  sequence s_short_wait;
    ##1 (!s_q.done)[*3] ##LAT1_REST s_q.done;
  endsequence

  sequence s_pair_drop;
    ##LAT1 (s_q.done && !s_q.wb.acc_we && !s_q.wb.cy_we);
  endsequence

  sequence s_bit_read;
    s_q.mem_rd && is_bit(s_q.kind) && !is_da_form(s_q.op.first);
  endsequence

  chk_adc_carry_out: assert property (@(posedge clk) disable iff (reset)
    fin && s_q.kind == K_ADC4 |-> s_q.wb.cy_we && s_q.wb.cy == chk_sum_c[4]
      && s_q.wb.acc == chk_sum_c[3:0])
    else $error("add-with-carry result or carry wrong");

  chk_source_kept: assert property (@(posedge clk) disable iff (reset)
    fin && pair_op |-> (dst_ea ? !s_q.wb.rr_we : !(s_q.wb.acc_we || s_q.wb.ext_we)))
    else $error("add wrote its source operand");

  chk_ads_carry_kept: assert property (@(posedge clk) disable iff (reset)
    s_q.done && is_ads(s_q.kind) |-> !s_q.wb.cy_we)
    else $error("add-and-skip touched carry");

  chk_ads_skip_flag: assert property (@(posedge clk) disable iff (reset)
    fin && s_q.kind == K_ADS4M |-> s_q.wb.acc == chk_sum_n[3:0]
      && skip_pending == chk_sum_n[4])
    else $error("add-and-skip sum or skip wrong");

  chk_pair_skip: assert property (@(posedge clk) disable iff (reset)
    accept && acc_pair_skip |-> s_pair_drop)
    else $error("paired add-and-skip not skipped");

  chk_pair_no_skip: assert property (@(posedge clk) disable iff (reset)
    fin && s_q.kind == K_ADS4I && s_q.no_skip |-> !skip_pending)
    else $error("paired add-and-skip raised a skip");

  chk_adc_timing: assert property (@(posedge clk) disable iff (reset)
    accept && !acc_skip && acc_kind == K_ADC8 |-> ##LAT2 s_q.done)
    else $error("pair add-with-carry length wrong");

  chk_ads_timing: assert property (@(posedge clk) disable iff (reset)
    accept && !acc_skip && acc_kind == K_ADS4I |-> s_short_wait)
    else $error("short add-and-skip length wrong");

  chk_bit_clear: assert property (@(posedge clk) disable iff (reset)
    fin && s_q.kind == K_BCLR |-> s_q.wb.mem_we && (s_q.wb.mem & one_hot) == 4'h0
      && (s_q.wb.mem | one_hot) == (s_q.memd | one_hot))
    else $error("bit clear result wrong");

  chk_bit_set: assert property (@(posedge clk) disable iff (reset)
    fin && s_q.kind == K_BSET |-> s_q.wb.mem_we && s_q.wb.mem == (s_q.memd | one_hot))
    else $error("bit set result wrong");

  chk_carry_and: assert property (@(posedge clk) disable iff (reset)
    fin && s_q.kind == K_BAND |-> s_q.wb.cy == (s_q.regs.carry & s_q.memd[s_q.bitn]))
    else $error("carry AND bit wrong");

  chk_carry_or: assert property (@(posedge clk) disable iff (reset)
    fin && s_q.kind == K_BOR |-> !s_q.wb.mem_we
      && s_q.wb.cy == (s_q.regs.carry | s_q.memd[s_q.bitn]))
    else $error("carry OR bit wrong");

  chk_carry_xor: assert property (@(posedge clk) disable iff (reset)
    fin && s_q.kind == K_CARRY_XOR_BIT |-> s_q.wb.cy == (s_q.regs.carry ^ s_q.memd[s_q.bitn]))
    else $error("carry XOR bit wrong");

  chk_bit_load: assert property (@(posedge clk) disable iff (reset)
    fin && s_q.kind == K_BTOM |-> s_q.wb.mem[s_q.bitn] == s_q.regs.carry && !s_q.wb.cy_we)
    else $error("bit load from carry wrong");

  chk_lidx_addr: assert property (@(posedge clk) disable iff (reset)
    s_bit_read ##0 (s_q.op.second[7:4] == LIDX_TAG) |-> s_q.bitn == s_q.regs.l[1:0]
      && s_q.mem_addr == {FIX_BANK, LIDX_TOP, s_q.op.second[3:0], s_q.regs.l[3:2]})
    else $error("L-indexed address wrong");

  chk_hbase_addr: assert property (@(posedge clk) disable iff (reset)
    s_bit_read ##0 (s_q.op.second[7:6] == 2'b00) |->
      s_q.mem_addr == {s_q.regs.bank, s_q.regs.h, s_q.op.second[3:0]})
    else $error("H-based address wrong");

  chk_fixed_addr: assert property (@(posedge clk) disable iff (reset)
    s_bit_read ##0 s_q.op.second[FIX_FLAG_POS] |-> s_q.mem_addr[11:8] == FIX_BANK
      && s_q.mem_addr[7:4] == (s_q.op.second[FIX_AREA_POS] ? FIX_AREA_HI : FIX_AREA_LO))
    else $error("fixed-area address wrong");

  chk_skip_no_effect: assert property (@(posedge clk) disable iff (reset)
    s_q.done && s_q.skipping |-> s_q.wb == '0 && !skip_pending && !s_q.prev_adc)
    else $error("skipped instruction had an effect");

endmodule

// >>> test_bit_ops_and_add_skip_decoder.sv
// Self-checking bench for the bit-operation and add-and-skip executor
module test_bit_ops_and_add_skip_decoder
  import bsd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, reset, issue, ready, mem_rd, done, skip_pending, sp;
  bsd_op_s     issue_op;
  bsd_regs_s   issue_regs;
  logic [11:0] mem_addr;
  logic [3:0]  mem_rdata;
  logic [1:0]  rr_sel;
  logic [7:0]  rr_rdata;
  bsd_wb_s     wb, w;
  int          miscompares, num_checks, n;

  bsd_decoder #(.MC_DIV(4)) u_bsd_decoder (
    .clk(clk), .reset(reset), .issue(issue), .issue_op(issue_op),
    .issue_regs(issue_regs), .ready(ready), .mem_rd(mem_rd), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata), .rr_sel(rr_sel), .rr_rdata(rr_rdata), .wb(wb),
    .done(done), .skip_pending(skip_pending)
  );

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic wrap_up();
    if (miscompares == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  // Issue one op, wait for done, capture the write-back at that cycle
  task automatic run(logic [7:0] f, logic [7:0] s, logic [1:0] len, bsd_regs_s r,
                     logic [3:0] md, int ncy);
    @(posedge clk);
    issue      <= 1'b1;
    issue_op   <= {f, s, len};
    issue_regs <= r;
    mem_rdata  <= md;
    @(posedge clk);
    issue <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end while (done !== 1'b1 && n < 40);
    w  = wb;
    sp = skip_pending;
    chk("cycles", n, ncy * 4);
  endtask

  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_adds();
    run(OP_ADC_A_MEM, 8'h00, 2'd1, {4'h9, 4'h0, 4'h5, 4'h6, 1'b1, 4'h3}, 4'h8, 1);
    chk("adc_addr", mem_addr, 12'h356);
    chk("adc_acc", {w.acc_we, w.acc, w.cy_we, w.cy}, 7'h4B);
    chk("adc_src", {w.mem_we, w.ext_we, w.rr_we}, 3'b000);
    rr_rdata <= 8'hAA;
    run(OP_PAIR_PFX, 8'hAA, 2'd2, {4'h3, 4'hC, 4'h0, 4'h0, 1'b0, 4'h0}, 4'h0, 2);
    chk("adc8_sel", rr_sel, 2'b01);
    chk("adc8_ea", {w.ext_we, w.ext, w.acc_we, w.acc, w.cy}, 11'h5BB);
    chk("adc8_src", w.rr_we, 1'b0);
  endtask

  task automatic t_skip();
    run({OP_ADS_A_IMM_HI, 4'h6}, 8'h00, 2'd1, {4'hC, 4'h0, 4'h0, 4'h0, 1'b1, 4'h0}, 4'h0, 1);
    chk("ads_acc", {w.acc_we, w.acc, w.cy_we, sp}, 7'h49);
    // Skipped op: only its fetch time, nothing written
    run(OP_ADC_A_MEM, 8'h00, 2'd1, {4'h1, 4'h0, 4'h0, 4'h0, 1'b1, 4'h0}, 4'hF, 1);
    chk("skip_we", {w.acc_we, w.cy_we, w.mem_we, sp}, 4'h0);
    run(OP_ADS_EA_IMM, 8'h12, 2'd2, {4'h3, 4'hC, 4'h0, 4'h0, 1'b0, 4'h0}, 4'h0, 2);
    chk("ads8_ea", {w.ext, w.acc, w.cy_we, sp}, 10'h354);
    run(OP_ADS_EA_IMM, 8'h20, 2'd2, {4'h0, 4'hF, 4'h0, 4'h0, 1'b0, 4'h0}, 4'h0, 2);
    chk("ads8_ovf", {w.ext, w.acc, sp}, 9'h021);
    run(OP_BIT_SET, 8'h07, 2'd2, {4'h0, 4'h0, 4'h2, 4'h0, 1'b0, 4'h1}, 4'h0, 2);
    chk("skip2_we", {w.mem_we, w.cy_we, sp}, 3'b000);
    run(OP_ADS_A_MEM, 8'h00, 2'd1, {4'h9, 4'h0, 4'h0, 4'h0, 1'b1, 4'h0}, 4'h8, 1);
    chk("adsm_acc", {w.acc_we, w.acc, w.cy_we, sp}, 7'h45);
    run(OP_CY_OR, 8'h00, 2'd2, {4'h0, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0}, 4'hF, 2);
    chk("skip3_we", {w.cy_we, w.mem_we, sp}, 3'b000);
  endtask

  // Decimal adjust pairing, with and without carry out of the first add
  task automatic t_pair();
    run(OP_ADC_A_MEM, 8'h00, 2'd1, {4'hE, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0}, 4'h9, 1);
    chk("dec_adc", {w.acc, w.cy}, 5'h0F);
    run({OP_ADS_A_IMM_HI, 4'hA}, 8'h00, 2'd1, {4'h7, 4'h0, 4'h0, 4'h0, 1'b1, 4'h0}, 4'h0, 1);
    chk("dec_skip", {w.acc_we, w.cy_we, sp}, 3'b000);
    run(OP_ADC_A_MEM, 8'h00, 2'd1, {4'h9, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0}, 4'h4, 1);
    run({OP_ADS_A_IMM_HI, 4'hA}, 8'h00, 2'd1, {4'hD, 4'h0, 4'h0, 4'h0, 1'b0, 4'h0}, 4'h0, 1);
    chk("dec_run", {w.acc_we, w.acc, sp}, 6'h2E);
  endtask

  task automatic t_bits();
    logic [7:0] ops [7] = '{OP_BIT_SET, OP_BIT_CLR, OP_CY_AND, OP_CY_OR, OP_CY_XOR,
                            OP_LD_TO_BIT, OP_LD_TO_CY};
    logic [3:0] em;
    logic       c, ec;
    for (int k = 0; k < 7; k++) begin
      for (int i = 0; i < 4; i++) begin
        // Pattern 0110 with carry 1,1,0,0 gives all four operand pairs
        c  = (i < 2);
        em = 4'h6;
        ec = c;
        case (k)
          0: em[i] = 1'b1;
          1: em[i] = 1'b0;
          2: ec = c & em[i];
          3: ec = c | em[i];
          4: ec = c ^ em[i];
          5: em[i] = c;
          default: ec = em[i];
        endcase
        run(ops[k], {2'b00, i[1:0], 4'h7}, 2'd2, {12'h000, 4'h0, c, 4'h1}, 4'h6, 2);
        chk("bit_addr", mem_addr, {4'h1, 4'h0, 4'h7});
        chk("bit_we", {w.mem_we, w.cy_we}, (k < 2 || k == 5) ? 2'b10 : 2'b01);
        if (w.mem_we === 1'b1) chk("bit_mem", w.mem, em);
        else chk("bit_cy", w.cy, ec);
      end
    end
  endtask

  task automatic t_addr();
    logic [7:0]  sb [3] = '{8'h45, 8'hA3, 8'hD5};
    logic [11:0] ea [3] = '{12'hFD6, 12'hFB3, 12'hFF5};
    logic [3:0]  ev [3] = '{4'h2, 4'h4, 4'h2};
    for (int k = 0; k < 3; k++) begin
      run(OP_BIT_SET, sb[k], 2'd2, {4'h0, 4'h0, 4'h7, 4'h9, 1'b0, 4'h1}, 4'h0, 2);
      chk("area_addr", mem_addr, ea[k]);
      chk("area_mem", {w.mem_we, w.mem}, {1'b1, ev[k]});
    end
  endtask

  initial begin
    reset      = 1'b1;
    issue      = 1'b0;
    issue_op   = '0;
    issue_regs = '0;
    mem_rdata  = 4'h0;
    rr_rdata   = 8'h00;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    t_adds();
    t_skip();
    t_pair();
    t_bits();
    t_addr();
    wrap_up();
  end

  // Some 44 ops of at most 10 clocks each; generous margin
  initial begin
    #20000;
    miscompares++;
    wrap_up();
  end
endmodule
